/* File: bench/tb_tmw_timer.sv */
// Self-checking bench for the waveform timer, one task per scenario.
// Assumes the checker is bound in and the pin model watches the pin.
`timescale 1ns/1ps
module tb_tmw_timer;
   logic       clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, pin;
   logic [2:0] addr_in = 3'h0;
   logic [7:0] wdata_in = 8'h00, rdata_out;
   logic       wave_output_out, wave_oe_out, match_flag_out;
   logic       overflow_flag_out;
   int         num_errors = 0, n_tests = 0;
   tmw_timer dut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in,
      .rd_in, .rdata_out, .wave_output_out, .wave_oe_out,
      .match_flag_out, .overflow_flag_out);
   tmw_pin_model pm (.clk_in(clk_in), .drive_in(wave_oe_out),
      .level_in(wave_output_out), .pin_out(pin));
   initial forever #20 clk_in = ~clk_in;
   task chk(input string s, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
      @(posedge clk_in) wr_in <= 1'b0;
      // Idle edge keeps a following strobe out of this time step
      @(posedge clk_in);
   endtask
   task rd(input logic [2:0] a, output logic [7:0] d);
      addr_in <= a; rd_in <= 1'b1;
      @(posedge clk_in) rd_in <= 1'b0;
      @(negedge clk_in) d = rdata_out;
      @(posedge clk_in);
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // Full periods only, so the count is phase independent
   task duty(input logic [1:0] m, a, input logic [7:0] c, input int n, e);
      int h;
      wr(3'h2, c); wr(3'h0, {4'h1, a, m}); cyc(800);
      h = 0;
      repeat (n) @(negedge clk_in) h += int'(pin === 1'b1);
      @(posedge clk_in);
      chk("high cycles", e, 16'(h));
   endtask
   task t_reset;
      logic [7:0] d;
      for (int i = 0; i < 5; i++) begin
         rd(3'(i), d); chk("reset reg", 8'h00, d);
      end
      wr(3'h5, 8'h5A); rd(3'h5, d); chk("unmapped", 8'h00, d);
      wr(3'h2, 8'hA5); rd(3'h2, d); chk("compare buf", 8'hA5, d);
      wr(3'h0, 8'h8C); rd(3'h0, d); chk("ctrl back", 8'h8C, d);
      wr(3'h0, 8'h00);
      $display("reset done");
   endtask
   task t_ctc;
      int dv[5] = '{1, 8, 64, 256, 1024};
      int g, i;
      logic v;
      // Near-BOTTOM compare written while stopped
      wr(3'h4, 8'h01); wr(3'h2, 8'h03);
      @(negedge clk_in) chk("drive enable", 1, wave_oe_out);
      for (int s = 1; s < 6; s++) begin
         wr(3'h0, {1'b0, 3'(s), 4'h6});
         @(negedge clk_in) v = pin;
         for (i = 0; i < 9000 && pin === v; i++) @(negedge clk_in);
         v = pin; g = 0;
         for (i = 0; i < 9000 && pin === v; i++) @(negedge clk_in) g++;
         @(posedge clk_in);
         chk("toggle gap", 16'(4 * dv[s-1]), 16'(g));
         chk("match flag", 1, match_flag_out);
      end
      wr(3'h0, 8'h12); wr(3'h4, 8'h03);
      @(negedge clk_in) chk("port data", 1, pin);
      $display("clear mode done");
   endtask
   task t_wrap;
      wr(3'h0, 8'h16); wr(3'h2, 8'h10); wr(3'h3, 8'h03); wr(3'h1, 8'h10);
      cyc(5);
      chk("blocked", 0, match_flag_out);
      cyc(300);
      chk("overflow", 1, overflow_flag_out);
      chk("late match", 1, match_flag_out);
      $display("wrap done");
   endtask
   task t_fast;
      duty(2'h3, 2'h2, 8'h40, 512, 130);
      duty(2'h3, 2'h3, 8'h40, 512, 382);
      duty(2'h3, 2'h2, 8'hFF, 512, 512);
      duty(2'h3, 2'h2, 8'h00, 512, 2);
      duty(2'h3, 2'h1, 8'h40, 512, 256);
      wr(3'h3, 8'h03); cyc(300);
      chk("fast ovf", 1, overflow_flag_out);
      $display("fast done");
   endtask
   task t_phase;
      duty(2'h1, 2'h2, 8'h40, 510, 128);
      duty(2'h1, 2'h3, 8'h40, 510, 382);
      duty(2'h1, 2'h2, 8'h00, 510, 0);
      duty(2'h1, 2'h2, 8'hFF, 510, 510);
      duty(2'h1, 2'h3, 8'h00, 510, 510);
      wr(3'h3, 8'h03); cyc(600);
      chk("phase ovf", 1, overflow_flag_out);
      $display("phase done");
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #4_000_000;
      num_errors++;
      summarize;
   end
   initial begin
      cyc(8);
      rst_n_in <= 1'b1;
      @(posedge clk_in);
      t_reset; t_ctc; t_wrap; t_fast; t_phase;
      summarize;
   end
endmodule

/* File: bench/tmw_pin_model.sv */
// Port pin beside the timer: driven level or a floating pattern.
// Assumes enable and level come from the timer's own clock domain.
`timescale 1ns/1ps
module tmw_pin_model (
   input  wire logic clk_in,
   input  wire logic drive_in,
   input  wire logic level_in,
   output logic      pin_out
);
   logic flt = 1'b0;
   // Undriven pin wanders so a stale level never passes
   always @(posedge clk_in) flt <= ~flt;
   assign pin_out = drive_in ? level_in : flt;
endmodule

/* File: bench/tmw_timer_monitor.sv */
// Port checker for the waveform timer, bound into tmw_timer.
// Assumes register writes land on the edge that samples wr_in.
`timescale 1ns/1ps
module tmw_timer_monitor (
   input wire logic       clk_in,
   input wire logic       rst_n_in,
   input wire logic [2:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic       wr_in,
   input wire logic       rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic       wave_output_out,
   input wire logic       wave_oe_out,
   input wire logic       match_flag_out,
   input wire logic       overflow_flag_out
);
   logic [7:0] ctrl_q, cmp_q, pin_q;
   logic [9:0] quiet;
   logic       clear_on_match_mode;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   assign clear_on_match_mode = ctrl_q == 8'h16 && cmp_q == 8'h03;
   // Shadows of written registers; quiet counts write-free cycles
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ctrl_q <= 8'h00;
         cmp_q  <= 8'h00;
         pin_q  <= 8'h00;
         quiet  <= 10'h000;
      end else begin
         if (wr_in && addr_in == 3'h0) ctrl_q <= wdata_in;
         if (wr_in && addr_in == 3'h2) cmp_q <= wdata_in;
         if (wr_in && addr_in == 3'h4) pin_q <= wdata_in;
         quiet <= wr_in ? 10'h000 : quiet + 10'(quiet != 10'h3FF);
      end
   end
   property p_rst;
      disable iff (1'b0) !rst_n_in |=> rdata_out == 8'h00 &&
         !wave_oe_out && !wave_output_out && !match_flag_out &&
         !overflow_flag_out;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_oe;
      wave_oe_out == pin_q[0];
   endproperty
   a_oe: assert property (p_oe) else $error("enable off dir");
   property p_port;
      ctrl_q[3:2] == 2'h0 |-> wave_output_out == pin_q[1];
   endproperty
   a_port: assert property (p_port) else $error("port data lost");
   property p_ctc_gap;
      clear_on_match_mode && $past(clear_on_match_mode) && !wr_in && $changed(wave_output_out)
         ##1 (clear_on_match_mode && !wr_in) [*4] |-> $changed(wave_output_out) &&
         $past(wave_output_out, 1) == $past(wave_output_out, 2) &&
         $past(wave_output_out, 2) == $past(wave_output_out, 3);
   endproperty
   a_ctc_gap: assert property (p_ctc_gap) else $error("toggle gap");
   property p_ctc_flag;
      clear_on_match_mode && $past(clear_on_match_mode) && $changed(wave_output_out) |-> match_flag_out;
   endproperty
   a_ctc_flag: assert property (p_ctc_flag) else $error("no flag");
   property p_fast_max;
      ctrl_q == 8'h1B && cmp_q == 8'hFF && quiet > 10'h258
         |-> wave_output_out;
   endproperty
   a_fast_max: assert property (p_fast_max) else $error("not high");
   property p_fast_spike;
      ctrl_q == 8'h1B && cmp_q == 8'h00 && quiet > 10'h258 &&
         wave_output_out |=> !wave_output_out;
   endproperty
   a_fast_spike: assert property (p_fast_spike) else $error("wide");
   property p_phase_ext;
      ctrl_q == 8'h19 && quiet > 10'h2BC && (cmp_q == 8'h00 ||
         cmp_q == 8'hFF) |-> wave_output_out == cmp_q[0];
   endproperty
   a_phase_ext: assert property (p_phase_ext) else $error("level");
   c_ctc: cover property (clear_on_match_mode && $changed(wave_output_out));
   c_fast: cover property (ctrl_q == 8'h1B && overflow_flag_out);
   c_phase: cover property (ctrl_q == 8'h19 && $rose(wave_output_out));
endmodule
bind tmw_timer tmw_timer_monitor mon (.clk_in, .rst_n_in, .addr_in,
   .wdata_in, .wr_in, .rd_in, .rdata_out, .wave_output_out,
   .wave_oe_out, .match_flag_out, .overflow_flag_out);

/* File: src/tmw_defines.svh */
// Constants for the 8-bit waveform timer: offsets, fields, resets.
// Assumes inclusion by bare name from design files only.
`ifndef TMW_DEFINES_SVH
`define TMW_DEFINES_SVH

// Register index on the plain register port
`define TMW_ADDR_CTRL     3'h0
`define TMW_ADDR_COUNT    3'h1
`define TMW_ADDR_COMPARE  3'h2
`define TMW_ADDR_FLAGS    3'h3
`define TMW_ADDR_PIN      3'h4

// Field positions
`define TMW_CTRL_MODE_LSB 0
`define TMW_CTRL_ACT_LSB  2
`define TMW_CTRL_CS_LSB   4
`define TMW_FLAG_MATCH    0
`define TMW_FLAG_OVF      1
`define TMW_PIN_DIR       0
`define TMW_PIN_DATA      1
`define TMW_PIN_WAVE      2

// Reset values
`define TMW_RST_BYTE      8'h00
`define TMW_RST_PRESC     10'h000

// Counter extremes
`define TMW_BOTTOM        8'h00
`define TMW_MAX           8'hFF

// Prescale tap masks: divide by 8, 64, 256, 1024
`define TMW_DIV8_MASK     10'h007
`define TMW_DIV64_MASK    10'h03F
`define TMW_DIV256_MASK   10'h0FF
`define TMW_DIV1024_MASK  10'h3FF

`endif

/* File: src/tmw_pkg.sv */
// Types shared by the waveform timer design.
// Assumes tmw_defines.svh for numeric constants.
package tmw_pkg;

   typedef enum logic [1:0] {
      TMW_NORMAL = 2'h0,
      TMW_PHASE  = 2'h1,
      TMW_CLEAR  = 2'h2,
      TMW_FAST   = 2'h3
   } tmw_mode_e;

   typedef struct packed {
      logic       unused;
      logic [2:0] clk_sel;
      logic [1:0] cmp_out_action;
      tmw_mode_e  wave_mode_sel;
   } tmw_ctrl_s;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tmw_req_s;

endpackage

/* File: src/tmw_timer.sv */
// 8-bit timer with one compare channel and waveform generation.
// Assumes a single 25 MHz clock and a same-clock register master.
`timescale 1ns/1ps
`include "tmw_defines.svh"

// Operation
// - Clear-on-match mode 2: counter returns to zero after equalling compare.
// - Clear-on-match mode sets match flag whenever counter reaches compare.
// - Clear-on-match compare writes unbuffered; missed match wraps past 0xFF.
// - Clear-on-match with action 1 toggles output on every match.
// - Clear-on-match sets overflow flag when counter rolls 0xFF to 0x00.
// - Waveform reaches pin only when its direction bit selects output.
// - Fast mode 3 counts BOTTOM to MAX, then back to BOTTOM.
// - Fast action 2 clears on match, sets at BOTTOM; 3 inverts.
// - Fast mode sets overflow flag once per period at MAX.
// - Fast mode compare writes go to a buffer, not the active value.
// - Fast: compare BOTTOM gives one-cycle spike, MAX gives constant level.
// - Fast action 1 toggles on each match, buffering kept.
// - Phase mode 1 counts up to MAX, turns without a hold, counts down.
// - Phase action 2 clears on up match, sets on down; 3 inverts.
// - Phase mode sets overflow flag each time counter reaches BOTTOM.
// - Phase compare BOTTOM keeps output low, MAX keeps high, inverted opposite.
// - Phase: output at MAX equals up-match result unless compare is MAX.
// - Phase: missed up match still yields its output transition.
// - Counter advances on prescaled enables: divide 1, 8, 64, 256, 1024.
// - PWM modes load buffered compare only at top or bottom.
// - Counter write blocks any match in the next timer cycle.
// - Action 0 leaves output register alone and returns pin to port.
module tmw_timer (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [2:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   output logic            wave_output_out,
   output logic            wave_oe_out,
   output logic            match_flag_out,
   output logic            overflow_flag_out
);

   tmw_pkg::tmw_req_s  req;
   tmw_pkg::tmw_ctrl_s ctrl;
   logic [7:0]         count_value;
   logic [7:0]         compare_value;
   logic [7:0]         compare_buf;
   logic               count_down;
   logic               match_block;
   logic               match_flag;
   logic               overflow_flag;
   logic               wave_reg;
   logic               pin_dir;
   logic               pin_data;
   logic [9:0]         presc;
   logic [7:0]         rdata;

   logic [7:0]         next_count;
   logic               next_down;
   logic               next_wave;
   logic [7:0]         rd_mux;

   assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

   // Decode
   wire wr_ctrl  = req.wr && req.addr == `TMW_ADDR_CTRL;
   wire wr_count = req.wr && req.addr == `TMW_ADDR_COUNT;
   wire wr_cmp   = req.wr && req.addr == `TMW_ADDR_COMPARE;
   wire wr_flags = req.wr && req.addr == `TMW_ADDR_FLAGS;
   wire wr_pin   = req.wr && req.addr == `TMW_ADDR_PIN;

   wire tmw_pkg::tmw_mode_e mode = ctrl.wave_mode_sel;
   wire [1:0] act      = ctrl.cmp_out_action;
   wire       is_pwm   = mode == tmw_pkg::TMW_FAST ||
                         mode == tmw_pkg::TMW_PHASE;

   // Timer enable from the free-running prescaler
   function automatic logic tap(input logic [9:0] c, input logic [9:0] m);
      tap = (c & m) == m;
   endfunction

   logic tick;
   always_comb begin
      case (ctrl.clk_sel)
         3'h1:    tick = 1'b1;
         3'h2:    tick = tap(presc, `TMW_DIV8_MASK);
         3'h3:    tick = tap(presc, `TMW_DIV64_MASK);
         3'h4:    tick = tap(presc, `TMW_DIV256_MASK);
         3'h5:    tick = tap(presc, `TMW_DIV1024_MASK);
         default: tick = 1'b0;
      endcase
   end

   // Extremes and compare events
   wire at_max    = count_value == `TMW_MAX;
   wire at_bottom = count_value == `TMW_BOTTOM;
   wire equal     = count_value == compare_value;
   wire match     = tick && equal && !match_block;

   // Phase mode: BOTTOM counts as rising, MAX handled separately
   wire up_match   = match && (!count_down || at_bottom) && !at_max;
   wire down_match = match && count_down && !at_bottom && !at_max;
   wire cmp_is_max = compare_value == `TMW_MAX;

   wire ovf_event =
      tick && ((mode == tmw_pkg::TMW_PHASE) ?
               (at_bottom && count_down) :
               at_max);

   wire clr_match = mode == tmw_pkg::TMW_CLEAR && match;

   // Next counter value
   always_comb begin
      next_count = count_value;
      next_down  = count_down;
      if (mode == tmw_pkg::TMW_PHASE) begin
         if (!count_down) begin
            if (at_max) begin
               next_down  = 1'b1;
               next_count = count_value - 8'h01;
            end else begin
               next_count = count_value + 8'h01;
            end
         end else if (at_bottom) begin
            next_down  = 1'b0;
            next_count = count_value + 8'h01;
         end else begin
            next_count = count_value - 8'h01;
         end
      end else if (clr_match) begin
         next_count = `TMW_BOTTOM;
      end else begin
         // Wraps MAX to BOTTOM in normal, clear and fast modes
         next_count = count_value + 8'h01;
         next_down  = 1'b0;
      end
   end

   // Output register actions
   always_comb begin
      next_wave = wave_reg;
      case (mode)
         tmw_pkg::TMW_FAST: begin
            if (match) begin
               case (act)
                  2'h1:    next_wave = !wave_reg;
                  2'h2:    next_wave = 1'b0;
                  2'h3:    next_wave = 1'b1;
                  default: next_wave = wave_reg;
               endcase
            end
            // Bottom action after match: MAX compare gives steady level
            if (tick && at_max) begin
               if (act == 2'h2) begin
                  next_wave = 1'b1;
               end else if (act == 2'h3) begin
                  next_wave = 1'b0;
               end
            end
         end
         tmw_pkg::TMW_PHASE: begin
            if (act[1]) begin
               if (up_match) begin
                  next_wave = act[0];
               end else if (down_match) begin
                  next_wave = !act[0];
               end else if (tick && at_max) begin
                  // Symmetric turn at top, also covers missed up match
                  next_wave = cmp_is_max ? !act[0] :
                              act[0];
               end
            end
         end
         default: begin
            if (match) begin
               case (act)
                  2'h1:    next_wave = !wave_reg;
                  2'h2:    next_wave = 1'b0;
                  2'h3:    next_wave = 1'b1;
                  default: next_wave = wave_reg;
               endcase
            end
         end
      endcase
   end

   // Read mux; unmapped reads return zero
   always_comb begin
      case (req.addr)
         `TMW_ADDR_CTRL:    rd_mux = ctrl;
         `TMW_ADDR_COUNT:   rd_mux = count_value;
         `TMW_ADDR_COMPARE: rd_mux = compare_buf;
         `TMW_ADDR_FLAGS:   rd_mux = {6'h00, overflow_flag, match_flag};
         `TMW_ADDR_PIN:     rd_mux = {5'h00, wave_reg, pin_data, pin_dir};
         default:           rd_mux = `TMW_RST_BYTE;
      endcase
   end

   // Buffered compare loads at top (phase) or bottom (fast)
   wire load_top = mode == tmw_pkg::TMW_PHASE && tick && at_max;
   wire load_bot = mode == tmw_pkg::TMW_FAST && tick && at_max;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         presc <= `TMW_RST_PRESC;
      end else begin
         presc <= presc + 10'h001;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ctrl     <= `TMW_RST_BYTE;
         pin_dir  <= 1'b0;
         pin_data <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= req.wdata;
         end
         if (wr_pin) begin
            pin_dir  <= req.wdata[`TMW_PIN_DIR];
            pin_data <= req.wdata[`TMW_PIN_DATA];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         count_value <= `TMW_BOTTOM;
         count_down  <= 1'b0;
         match_block <= 1'b0;
      end else if (wr_count) begin
         count_value <= req.wdata;
         match_block <= 1'b1;
      end else if (tick) begin
         count_value <= next_count;
         count_down  <= next_down;
         match_block <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         compare_buf   <= `TMW_RST_BYTE;
         compare_value <= `TMW_RST_BYTE;
      end else begin
         if (wr_cmp) begin
            compare_buf <= req.wdata;
         end
         if (wr_cmp && !is_pwm) begin
            compare_value <= req.wdata;
         end else if (!is_pwm) begin
            compare_value <= compare_buf;
         end else if (load_top || load_bot) begin
            compare_value <= compare_buf;
         end
      end
   end

   // Set wins over a software clear in the same cycle
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         match_flag    <= 1'b0;
         overflow_flag <= 1'b0;
      end else begin
         match_flag    <= match || (match_flag &&
                          !(wr_flags && req.wdata[`TMW_FLAG_MATCH]));
         overflow_flag <= ovf_event || (overflow_flag &&
                          !(wr_flags && req.wdata[`TMW_FLAG_OVF]));
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wave_reg <= 1'b0;
         rdata    <= `TMW_RST_BYTE;
      end else begin
         wave_reg <= next_wave;
         rdata    <= req.rd ? rd_mux : `TMW_RST_BYTE;
      end
   end

   // Pin: waveform only when action nonzero, driven only as output
   assign wave_output_out   = (act != 2'h0) ? wave_reg : pin_data;
   assign wave_oe_out       = pin_dir;
   assign rdata_out         = rdata;
   assign match_flag_out    = match_flag;
   assign overflow_flag_out = overflow_flag;

endmodule
